// ==== core/fcp_defines.svh ====
// Register map, field positions and reset values of the four-channel PWM
`ifndef FCP_DEFINES_SVH
`define FCP_DEFINES_SVH

`define FCP_IDX_CFG 10'h040
`define FCP_IDX_POLCLK 10'h041
`define FCP_IDX_EN 10'h042
`define FCP_IDX_PRES 10'h043
`define FCP_IDX_SCALA 10'h044
`define FCP_IDX_SCNTA 10'h045
`define FCP_IDX_SCALB 10'h046
`define FCP_IDX_SCNTB 10'h047
`define FCP_IDX_CNT0 10'h048
`define FCP_IDX_PER0 10'h04c
`define FCP_IDX_DTY0 10'h050
`define FCP_IDX_CTL 10'h054
`define FCP_IDX_TST 10'h055
`define FCP_IDX_PDATA 10'h056
`define FCP_IDX_PDIR 10'h057

`define FCP_CFG_JOIN01 6
`define FCP_CFG_JOIN23 7
`define FCP_CFG_PSA_LSB 3
`define FCP_CFG_PSB_LSB 0
`define FCP_POL_CLK_LSB 4
`define FCP_CTL_CENTER 0
`define FCP_TST_DISCR 7
`define FCP_TST_DISCP 6
`define FCP_TST_NO_SCALE_RELOAD_TEST 5

`define FCP_PER_RST 8'hff
`define FCP_DTY_RST 8'hff
`define FCP_ZERO8 8'h00

`endif

// ==== core/fcp_pkg.sv ====
// Types shared by the PWM files
package fcp_pkg;
	typedef logic [7:0] fcp_byte_t;
	typedef logic [15:0] fcp_word_t;
	typedef enum logic {FCP_UP = 1'b0, FCP_DOWN = 1'b1} fcp_dir_t;
	typedef struct packed {
		logic roll;
		fcp_dir_t dir;
		fcp_word_t cnt;
	} fcp_step_t;
endpackage : fcp_pkg

// ==== core/fcp_pwm.sv ====
// Four-channel PWM top with APB registers and port pin multiplexing
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fcp_defines.svh"
module fcp_pwm (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic special_mode,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] pin_in,
	output logic [3:0] pin_out,
	output logic [3:0] pin_oe
);
	// Bus decode
	logic [9:0] idx;
	logic aligned;
	logic acc;
	logic wr;
	logic mapped;
	logic [7:0] rd;
	logic [7:0] wd;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;

	// Configuration
	fcp_pkg::fcp_byte_t cfg, next_cfg;
	fcp_pkg::fcp_byte_t polclk, next_polclk;
	logic [3:0] en, next_en;
	logic [6:0] pres, next_pres;
	fcp_pkg::fcp_byte_t scal_a, next_scal_a;
	fcp_pkg::fcp_byte_t scal_b, next_scal_b;
	logic center, next_center;
	logic [2:0] tst, next_tst;
	logic [3:0] pdata, next_pdata;
	logic [3:0] pdir, next_pdir;

	// Channels
	fcp_pkg::fcp_byte_t per_buf [4];
	fcp_pkg::fcp_byte_t dty_buf [4];
	fcp_pkg::fcp_byte_t per_act [4];
	fcp_pkg::fcp_byte_t dty_act [4];
	fcp_pkg::fcp_byte_t cnt [4];
	fcp_pkg::fcp_byte_t next_per_buf [4];
	fcp_pkg::fcp_byte_t next_dty_buf [4];
	fcp_pkg::fcp_byte_t next_per_act [4];
	fcp_pkg::fcp_byte_t next_dty_act [4];
	fcp_pkg::fcp_byte_t next_cnt [4];
	fcp_pkg::fcp_dir_t dir [4];
	fcp_pkg::fcp_dir_t next_dir [4];
	logic [3:0] wave, next_wave;
	logic [3:0] armed, next_armed;

	// Pins
	logic [3:0] sync1, sync2, sync3, pin_lvl;
	logic [3:0] next_pin_lvl;
	logic [3:0] next_pin_out;
	logic [3:0] next_pin_oe;

	// Clocks
	logic run;
	logic tick_a;
	logic tick_b;
	logic tick_sa;
	logic tick_sb;
	logic [3:0] ct;
	logic [1:0] joined;
	logic [3:0] owner;
	logic [7:0] scnt_a;
	logic [7:0] scnt_b;
	logic ld_a;
	logic ld_b;
	logic discr;
	logic discp;
	logic no_scale_reload_test;

	function automatic logic div_tick(input logic [6:0] p, input logic [2:0] k);
		logic [7:0] m;
		m = (8'h01 << k) - 8'h01;
		return (p & m[6:0]) == m[6:0];
	endfunction : div_tick

	function automatic fcp_pkg::fcp_step_t step(input fcp_pkg::fcp_word_t c,
		input fcp_pkg::fcp_word_t per, input fcp_pkg::fcp_dir_t d,
		input logic ctr, input logic nop);
		fcp_pkg::fcp_step_t s;
		s.roll = 1'b0;
		s.dir = d;
		s.cnt = c + 16'h0001;
		if (ctr) begin
			if (d == fcp_pkg::FCP_UP) begin
				if (c == per) begin
					s.dir = fcp_pkg::FCP_DOWN;
					s.cnt = c - 16'h0001;
				end
			end else if (c == 16'h0000) begin
				s.dir = fcp_pkg::FCP_UP;
				s.roll = 1'b1;
			end else begin
				s.cnt = c - 16'h0001;
			end
		end else if (c == per && !nop) begin
			s.cnt = 16'h0000;
			s.roll = 1'b1;
		end
		return s;
	endfunction : step

	assign idx = paddr[11:2];
	assign aligned = paddr[1:0] == 2'b00;
	assign acc = psel & penable & pready;
	assign wr = acc & pwrite;
	assign wd = pwdata[7:0];
	assign discr = special_mode & tst[2];
	assign discp = special_mode & tst[1];
	assign no_scale_reload_test = special_mode & tst[0];
	assign joined = {cfg[`FCP_CFG_JOIN23], cfg[`FCP_CFG_JOIN01]};
	assign owner = {~joined[1], 1'b1, ~joined[0], 1'b1};
	assign run = |en;
	assign tick_a = run & div_tick(pres, cfg[`FCP_CFG_PSA_LSB +: 3]);
	assign tick_b = run & div_tick(pres, cfg[`FCP_CFG_PSB_LSB +: 3]);
	assign ld_a = wr & aligned & idx == `FCP_IDX_SCALA & ~no_scale_reload_test;
	assign ld_b = wr & aligned & idx == `FCP_IDX_SCALB & ~no_scale_reload_test;

	fcp_scaler u_scale_a (
		.clock(clock),
		.rst_n(rst_n),
		.tick_in(tick_a),
		.load(ld_a),
		.value(next_scal_a),
		.count(scnt_a),
		.tick_out(tick_sa)
	);

	fcp_scaler u_scale_b (
		.clock(clock),
		.rst_n(rst_n),
		.tick_in(tick_b),
		.load(ld_b),
		.value(next_scal_b),
		.count(scnt_b),
		.tick_out(tick_sb)
	);

	// Per-channel clock select, gated by enable on system clock edges
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_clk
			if (g < 2) begin : g_a
				assign ct[g] = polclk[`FCP_POL_CLK_LSB + g] ? tick_sa : tick_a;
			end else begin : g_b
				assign ct[g] = polclk[`FCP_POL_CLK_LSB + g] ? tick_sb : tick_b;
			end
		end
	endgenerate

	// Read decode
	always_comb begin
		rd = `FCP_ZERO8;
		mapped = aligned;
		if (idx == `FCP_IDX_CFG) begin
			rd = cfg;
		end else if (idx == `FCP_IDX_POLCLK) begin
			rd = polclk;
		end else if (idx == `FCP_IDX_EN) begin
			rd = {4'h0, en};
		end else if (idx == `FCP_IDX_PRES) begin
			rd = {1'b0, pres};
		end else if (idx == `FCP_IDX_SCALA) begin
			rd = scal_a;
		end else if (idx == `FCP_IDX_SCNTA) begin
			rd = scnt_a;
		end else if (idx == `FCP_IDX_SCALB) begin
			rd = scal_b;
		end else if (idx == `FCP_IDX_SCNTB) begin
			rd = scnt_b;
		end else if (idx >= `FCP_IDX_CNT0 && idx < `FCP_IDX_PER0) begin
			rd = cnt[idx[1:0]];
		end else if (idx >= `FCP_IDX_PER0 && idx < `FCP_IDX_DTY0) begin
			rd = per_buf[idx[1:0]];
		end else if (idx >= `FCP_IDX_DTY0 && idx < `FCP_IDX_CTL) begin
			rd = dty_buf[idx[1:0]];
		end else if (idx == `FCP_IDX_CTL) begin
			rd = {7'h00, center};
		end else if (idx == `FCP_IDX_TST) begin
			rd = {tst, 5'h00};
		end else if (idx == `FCP_IDX_PDATA) begin
			rd = {4'h0, (pdir & pdata) | (~pdir & pin_lvl)};
		end else if (idx == `FCP_IDX_PDIR) begin
			rd = {4'h0, pdir};
		end else begin
			mapped = 1'b0;
		end
	end

	// Bus answer: one wait state, then pready with data
	always_comb begin
		next_pready = psel & penable & ~pready;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		if (psel & penable & ~pready) begin
			next_prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd};
			next_pslverr = ~mapped;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// Configuration registers and channel engines
	always_comb begin
		fcp_pkg::fcp_word_t c16;
		fcp_pkg::fcp_word_t p16;
		fcp_pkg::fcp_word_t d16;
		fcp_pkg::fcp_step_t s;
		logic [3:0] ue;
		logic [3:0] tk;
		logic [3:0] cw;
		logic [3:0] latch;
		logic wide;
		logic hit;
		logic pol;
		integer lo;
		c16 = 16'h0000;
		p16 = 16'h0000;
		d16 = 16'h0000;
		s = '0;
		wide = 1'b0;
		hit = 1'b0;
		pol = 1'b0;
		lo = 0;
		next_cfg = cfg;
		next_polclk = polclk;
		next_en = en;
		next_scal_a = scal_a;
		next_scal_b = scal_b;
		next_center = center;
		next_pdata = pdata;
		next_pdir = pdir;
		next_tst = special_mode ? tst : 3'h0;
		next_pres = run ? pres + 7'h01 : pres;
		next_wave = wave;
		cw = 4'h0;
		latch = 4'h0;
		ue = 4'h0;
		tk = 4'h0;
		if (wr && aligned) begin
			if (idx == `FCP_IDX_CFG) begin
				next_cfg = wd;
			end else if (idx == `FCP_IDX_POLCLK) begin
				next_polclk = wd;
			end else if (idx == `FCP_IDX_EN) begin
				next_en = wd[3:0];
			end else if (idx == `FCP_IDX_PRES && special_mode) begin
				next_pres = wd[6:0];
			end else if (idx == `FCP_IDX_SCALA) begin
				next_scal_a = wd;
			end else if (idx == `FCP_IDX_SCALB) begin
				next_scal_b = wd;
			end else if (idx == `FCP_IDX_CTL) begin
				next_center = wd[`FCP_CTL_CENTER];
			end else if (idx == `FCP_IDX_TST && special_mode) begin
				next_tst = wd[7:5];
			end else if (idx == `FCP_IDX_PDATA) begin
				next_pdata = wd[3:0];
			end else if (idx == `FCP_IDX_PDIR) begin
				next_pdir = wd[3:0];
			end
		end
		for (int i = 0; i < 4; i++) begin
			next_per_buf[i] = per_buf[i];
			next_dty_buf[i] = dty_buf[i];
			next_cnt[i] = cnt[i];
			next_dir[i] = dir[i];
			hit = wr & aligned;
			if (hit && idx == `FCP_IDX_PER0 + 10'(i)) begin
				next_per_buf[i] = wd;
			end
			if (hit && idx == `FCP_IDX_DTY0 + 10'(i)) begin
				next_dty_buf[i] = wd;
			end
			cw[i] = hit && idx == `FCP_IDX_CNT0 + 10'(i);
			// Low half of a joined pair follows the high half's enable
			ue[i] = owner[i] ? en[i] : en[i ^ 1];
			tk[i] = ue[i] & ct[joined[i / 2] ? (i | 1) : i];
		end
		// Step each unit: a joined pair runs as one 16-bit counter
		for (int u = 0; u < 4; u++) begin
			lo = u | 1;
			wide = (u % 2 == 0) && joined[u / 2];
			pol = polclk[u];
			if (owner[u]) begin
				c16 = wide ? {cnt[u], cnt[lo]} : {8'h00, cnt[u]};
				p16 = wide ? {per_act[u], per_act[lo]} : {8'h00, per_act[u]};
				d16 = wide ? {dty_act[u], dty_act[lo]} : {8'h00, dty_act[u]};
				if (wide ? ue[u] & ct[lo] : tk[u]) begin
					s = step(c16, p16, dir[u], center, discp);
					next_dir[u] = s.dir;
					if (wide) begin
						next_cnt[u] = s.cnt[15:8];
						next_cnt[lo] = s.cnt[7:0];
						latch[lo] = s.roll;
					end else begin
						next_cnt[u] = s.cnt[7:0];
					end
					latch[u] = s.roll;
					// Output set by count against duty; held at the polarity level when duty reaches period
					next_wave[u] = pol ^ ((d16 < p16) &&
						((center && s.dir == fcp_pkg::FCP_UP) ? s.cnt >= d16 : s.cnt > d16));
				end
			end
		end
		// Counter write clears the count (kept when discr is set) and forces the buffered values in
		for (int i = 0; i < 4; i++) begin
			if (cw[i]) begin
				next_cnt[i] = discr ? cnt[i] : `FCP_ZERO8;
				next_dir[i] = fcp_pkg::FCP_UP;
				latch[i] = 1'b1;
				if (joined[i / 2]) begin
					latch[i ^ 1] = 1'b1;
				end
				if (owner[i]) begin
					next_wave[i] = polclk[i];
				end
			end
		end
		for (int i = 0; i < 4; i++) begin
			next_per_act[i] = per_act[i];
			next_dty_act[i] = dty_act[i];
			if (latch[i] || !ue[i]) begin
				next_per_act[i] = next_per_buf[i];
				next_dty_act[i] = next_dty_buf[i];
			end
			// Pin shows the waveform from the first channel clock after enable
			next_armed[i] = owner[i] & en[i] & (armed[i] | tk[i]);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= `FCP_ZERO8;
			polclk <= `FCP_ZERO8;
			en <= 4'h0;
			pres <= 7'h00;
			scal_a <= `FCP_ZERO8;
			scal_b <= `FCP_ZERO8;
			center <= 1'b0;
			tst <= 3'h0;
			pdata <= 4'h0;
			pdir <= 4'h0;
			wave <= 4'h0;
			armed <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				per_buf[i] <= `FCP_PER_RST;
				dty_buf[i] <= `FCP_DTY_RST;
				per_act[i] <= `FCP_PER_RST;
				dty_act[i] <= `FCP_DTY_RST;
				cnt[i] <= `FCP_ZERO8;
				dir[i] <= fcp_pkg::FCP_UP;
			end
		end else begin
			cfg <= next_cfg;
			polclk <= next_polclk;
			en <= next_en;
			pres <= next_pres;
			scal_a <= next_scal_a;
			scal_b <= next_scal_b;
			center <= next_center;
			tst <= next_tst;
			pdata <= next_pdata;
			pdir <= next_pdir;
			wave <= next_wave;
			armed <= next_armed;
			for (int i = 0; i < 4; i++) begin
				per_buf[i] <= next_per_buf[i];
				dty_buf[i] <= next_dty_buf[i];
				per_act[i] <= next_per_act[i];
				dty_act[i] <= next_dty_act[i];
				cnt[i] <= next_cnt[i];
				dir[i] <= next_dir[i];
			end
		end
	end

	// Pin input filter and output multiplexing
	always_comb begin
		next_pin_lvl = ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & pin_lvl);
		next_pin_out = (armed & wave) | (~armed & pdata);
		next_pin_oe = (owner & en) | pdir;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
			sync3 <= 4'h0;
			pin_lvl <= 4'h0;
			pin_out <= 4'h0;
			pin_oe <= 4'h0;
		end else begin
			sync1 <= pin_in;
			sync2 <= sync1;
			sync3 <= sync2;
			pin_lvl <= next_pin_lvl;
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
		end
	end
endmodule : fcp_pwm
`default_nettype wire

// ==== core/fcp_scaler.sv ====
// Scale down-counter making the scaled clock tick
`timescale 1ns/1ps
`default_nettype none
module fcp_scaler (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic tick_in,
	input wire logic load,
	input wire logic [7:0] value,
	output logic [7:0] count,
	output logic tick_out
);
	logic half;
	logic [7:0] next_count;
	logic next_half;

	always_comb begin
		next_count = count;
		next_half = half;
		if (load) begin
			next_count = value;
		end else if (tick_in) begin
			if (count == 8'h00) begin
				next_count = value;
				next_half = ~half;
			end else begin
				next_count = count - 8'h01;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count <= 8'h00;
			half <= 1'b0;
		end else begin
			count <= next_count;
			half <= next_half;
		end
	end

	// One tick per full scaled period: reload while high half ends
	assign tick_out = tick_in & ~load & (count == 8'h00) & half;
endmodule : fcp_scaler
`default_nettype wire

// ==== sim/fcp_pins_model.sv ====
// Far-side model of the four port pins and their external source
`timescale 1ns/1ps
`default_nettype none
module fcp_pins_model (
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	input wire logic [3:0] ext_level,
	output logic [3:0] pin_in
);
	// Device drive wins; an undriven pin shows the external level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : fcp_pins_model
`default_nettype wire

// ==== sim/fcp_pwm_asserts.sv ====
// Bus and pin checks on the PWM top ports
`timescale 1ns/1ps
`default_nettype none
module fcp_pwm_asserts (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic special_mode,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] pin_in,
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	a_ready_one: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered after one wait state");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_err_read_zero: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("refused access returned data");
	a_write_data_zero: assert property (pready && pwrite |-> prdata == 32'h0)
		else $error("write answer carried read data");
	a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read data above the byte not zero");
	a_pres_seven_bit: assert property (pready && !pwrite && paddr == 12'h10c
		|-> !prdata[7])
		else $error("prescaler read wider than seven bits");
	a_enable_drives_pin: assert property (pready && pwrite && paddr == 12'h108
		&& pwdata[0] |-> ##2 pin_oe[0])
		else $error("enabled channel 0 not driving its pin");
endmodule : fcp_pwm_asserts
bind fcp_pwm fcp_pwm_asserts chk_u (.clock, .rst_n, .special_mode, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe);
`default_nettype wire

// ==== sim/test_four_channel_pwm_with_prescalers.sv ====
// Self-checking bench for the four-channel PWM
`timescale 1ns/1ps
`default_nettype none
module test_four_channel_pwm_with_prescalers;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic special_mode = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] pin_in;
	logic [3:0] pin_out;
	logic [3:0] pin_oe;
	logic [3:0] ext_level = 4'h0;
	logic [31:0] mdl [int];
	logic [31:0] rdat;
	logic rerr;
	int fail_count = 0;
	int n_checks = 0;
	int seed = 23373;
	int per, dty, sel, csel, pol, jn, win, cnt;
	int ctr, ch, len, hi, ex;
	always #2.5 clock = ~clock;
	fcp_pwm dut_u (.clock, .rst_n, .special_mode, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe);
	fcp_pins_model pins_u (.pin_out, .pin_oe, .ext_level, .pin_in);
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
		if (mdl.exists(a) && ((a != 12'h10c && a != 12'h154) || special_mode))
			mdl[a] = {24'h0, d};
		if (a == 12'h10c)
			mdl[a][7] = 1'b0;
		if (a == 12'h110 && !(special_mode && mdl[12'h154][5]))
			mdl[12'h114] = {24'h0, d};
	endtask : wr
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
		chk("read data", mdl.exists(a) ? mdl[a] : 32'h0, rdat);
		chk("slave error", {31'h0, !mdl.exists(a)}, {31'h0, rerr});
	endtask : rd
	initial begin
		#200000;
		fail_count++;
		conclude();
	end
	initial begin
		for (int a = 12'h100; a <= 12'h15c; a += 4)
			mdl[a] = (a >= 12'h130 && a < 12'h150) ? 32'hff : 32'h0;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		for (int a = 12'h100; a <= 12'h15c; a += 4)
			rd(a[11:0]);
		wr(12'h204, 8'h5a);
		rd(12'h204);
		wr(12'h100, 8'h38);
		wr(12'h110, 8'h5a);
		rd(12'h114);
		special_mode <= 1'b1;
		wr(12'h154, 8'h20);
		wr(12'h110, 8'h33);
		rd(12'h114);
		wr(12'h10c, 8'h55);
		repeat (20) @(posedge clock);
		rd(12'h10c);
		special_mode <= 1'b0;
		mdl[12'h154] = 32'h0;
		wr(12'h10c, 8'h11);
		rd(12'h10c);
		rd(12'h154);
		ext_level <= 4'($random(seed));
		wr(12'h15c, 8'h08);
		wr(12'h158, 8'h0c);
		mdl[12'h158] = {28'h0, (ext_level & 4'h7) | 4'h8};
		rd(12'h158);
		chk("gpio drive", 32'h3, {30'h0, pin_out[3], pin_oe[3]});
		for (int i = 0; i < 8; i++) begin
			pol = i % 2;
			sel = i % 3;
			csel = (i == 3);
			jn = (i == 5 || i == 7);
			ctr = (i == 6);
			ch = (i == 7) ? 2 : 0;
			per = 3 + ($unsigned($random(seed)) % 7);
			dty = (i == 4) ? per + 2 : ctr + $unsigned($random(seed)) % (per - ctr);
			len = ctr ? 2 * per : per + 1;
			hi = ctr ? 2 * dty : dty + 1;
			win = (len << sel) * (csel ? 4 : 1);
			wr(12'h108, 8'h00);
			wr(12'h150, 8'(ctr));
			wr(12'h100, 8'(jn * (64 << (ch / 2)) + (sel << (ch ? 0 : 3))));
			wr(12'h104, 8'((csel * 16 + pol) << ch));
			wr(12'h110, 8'h01);
			wr(12'(12'h130 + 4 * (ch + jn)), 8'(per));
			if (i != 1)
				wr(12'(12'h140 + 4 * (ch + jn)), 8'(dty));
			if (jn)
				wr(12'(12'h130 + 4 * ch), 8'h00);
			if (jn)
				wr(12'(12'h140 + 4 * ch), 8'h00);
			rd(12'(12'h130 + 4 * ch));
			wr(12'(12'h120 + 4 * ch), 8'h00);
			wr(12'h108, 8'(1 << ch));
			if (i == 1)
				wr(12'h140, 8'(dty));
			repeat (3 * win + 20) @(posedge clock);
			cnt = 0;
			repeat (win) begin
				@(negedge clock);
				cnt += (pin_out[ch] === pol[0]);
			end
			ex = dty >= per ? win : hi * win / len;
			chk("duty time", ex, cnt);
			chk("pin enables", 32'h8 | (1 << ch), {28'h0, pin_oe});
		end
		conclude();
	end
endmodule : test_four_channel_pwm_with_prescalers
`default_nettype wire
